// ===== hw/drc_cfg.svh
// Constants of the level compressor: register map, fields, timing
// Assumes inclusion by the package and by every design module
`ifndef LVL_CMP_CFG_SVH
`define LVL_CMP_CFG_SVH
// Register indices; the byte address is four times the index
`define IDX_CTRL_A 8'h7B
`define IDX_CTRL_B 8'h7C
`define IDX_CTRL_C 8'h7D
`define IDX_CTRL_D 8'h7E
`define IDX_STATUS 8'h7F
// Register reset values
`define RST_CTRL_A 16'h0F11
`define RST_CTRL_B 16'h0000
`define RST_CTRL_C 16'h0484
`define RST_CTRL_D 16'h0600
// Field positions
`define ON_BIT 15
`define PATH_BIT 14
`define FLOOR_F 3:2
`define CEIL_F 1:0
`define ATT_F 15:12
`define REL_F 11:8
`define KNEE_F 7:2
`define KOUT_F 15:11
`define USLOPE_F 10:8
`define LSLOPE_F 15:13
`define INIT_F 12:8
// Field limits and codes
`define KNEE_MAX 6'h3C
`define KOUT_MAX 5'h1E
`define USLOPE_ZERO 3'h5
`define LSLOPE_ZERO 3'h4
`define ATT_MIN 4'h1
`define ATT_MAX 4'hB
`define REL_MAX 4'h8
`define INIT_UNITY 5'h06
// Gain arithmetic in 0.75 dB units
`define INIT_STEP 10'sh004
`define FLOOR_STEP 10'sh008
`define CEIL_0 10'sh010
`define CEIL_1 10'sh018
`define CEIL_2 10'sh020
`define CEIL_3 10'sh030
`define GAIN_ONE 10'sh001
`define SHIFT_BIAS 10'sh003
`define FRAC_BITS 17
`define FRAC_0 16'sh4000
`define FRAC_1 16'sh45CB
`define FRAC_2 16'sh4C1C
`define FRAC_3 16'sh52FF
`define FRAC_4 16'sh5A82
`define FRAC_5 16'sh62B4
`define FRAC_6 16'sh6BA2
`define FRAC_7 16'sh7560
`define PCM_MAX 16'sh7FFF
`define PCM_MIN 16'sh8000
// Level meter
`define AVG_SHIFT 6
`define MS_TOP 30
`define LVL_PER_BIT 8'h04
// Timing: sample rate and time per 6 dB at the lowest code
`define SAMPLE_HZ 64'd48000
`define ATTACK_BASE_NS 64'd181000
`define RELEASE_BASE_NS 64'd186000000
`define NS_PER_S 64'd1000000000
`define STEPS_6DB 64'd8
// Widths
`define SAMPLE_W 16
`define FIFO_DEPTH 8
`define FIFO_AW 3
`endif

// ===== hw/drc_pkg.sv
// Types shared by the level compressor design files
// Assumes drc_cfg.svh on the include path
`include "drc_cfg.svh"
package level_pkg;
    typedef logic signed [`SAMPLE_W-1:0] pcm_t;
    typedef logic signed [9:0] gain_t;
    typedef struct packed {
        logic valid;
        pcm_t pcm;
    } sample_s;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [9:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_s;
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_s;
endpackage

// ===== hw/level_compressor.sv
// Level compressor: register file, gain tracker and sample paths
// Assumes a classic Wishbone master and stream partners on ref_clk
//
// Behaviour
// - Gain control acts only while enabled
// - Path select bit picks record or playback
// - Knee splits upper and lower compression regions
// - Slope one keeps gain, zero holds output
// - Full-scale output follows knee minus slope
// - Knee threshold in 0.75 dB steps
// - Knee output level in 0.75 dB steps
// - Upper slope code decode, reset one sixteenth
// - Lower slope code decode, reset unity
// - Gain never below programmed floor
// - Gain never above programmed ceiling
// - Decisions use averaged RMS level
// - Loud lowers gain, quiet raises gain
// - Attack time doubles per code step
// - Release time doubles per code step
// - Enable loads startup gain value
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`include "drc_cfg.svh"
module level_compressor (
    // Clock and reset
    input  wire logic           ref_clk,
    input  wire logic           rst_b,
    // Wishbone slave
    input  level_pkg::wb_req_s  wbReq,
    output level_pkg::wb_rsp_s  wbRsp,
    // Record path
    input  level_pkg::sample_s  recIn,
    output logic                recInReady,
    output level_pkg::sample_s  recOut,
    input  wire logic           recOutReady,
    // Playback path
    input  level_pkg::sample_s  playIn,
    output logic                playInReady,
    output level_pkg::sample_s  playOut,
    input  wire logic           playOutReady
);
    import level_pkg::*;

    // ************************************************************
    // Constants
    // ************************************************************
    localparam logic [19:0] ATT_SMP = 20'((`ATTACK_BASE_NS * `SAMPLE_HZ)
        / (`NS_PER_S * `STEPS_6DB));
    localparam logic [19:0] REL_SMP = 20'((`RELEASE_BASE_NS * `SAMPLE_HZ)
        / (`NS_PER_S * `STEPS_6DB));

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [1:0]  rstSyncQ;
    logic        rstN;
    logic [15:0] ctrlAQ;
    logic [15:0] ctrlBQ;
    logic [15:0] ctrlCQ;
    logic [15:0] ctrlDQ;
    logic        ackQ;
    logic [31:0] rdatQ;
    logic [15:0] rdMux;
    logic [7:0]  idx;
    logic        reqLive;
    logic        wrHit;
    logic        on;
    logic        playSel;
    logic        onQ;
    sample_s     actIn;
    logic        actOutReady;
    logic        fifoInReady;
    logic        fifoOutValid;
    pcm_t        fifoOutPcm;
    pcm_t        gained;
    logic        fire;
    logic [7:0]  level;
    logic [5:0]  knee;
    logic [4:0]  kout;
    gain_t       diff;
    gain_t       outAtt;
    gain_t       tgt;
    gain_t       floorG;
    gain_t       ceilG;
    gain_t       initG;
    gain_t       gainQ;
    logic [3:0]  attCode;
    logic [3:0]  relCode;
    logic        attOk;
    logic        relOk;
    logic [19:0] attLim;
    logic [19:0] relLim;
    logic [19:0] stepCntQ;
    logic        down;
    logic        up;
    logic        stepDue;

    // ************************************************************
    // Functions
    // ************************************************************
    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  sel);
        return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    // Slope as a right shift; the zero code and above hold the output
    function automatic gain_t slope(input gain_t d, input logic [2:0] code,
                                    input logic [2:0] zero);
        if (code >= zero) return '0;
        return d >>> code;
    endfunction

    // Hold a gain between floor and ceiling
    function automatic gain_t clampG(input gain_t g, input gain_t lo,
                                     input gain_t hi);
        if (g < lo) return lo;
        if (g > hi) return hi;
        return g;
    endfunction

    // Multiply a sample by 2^(g/8) with saturation
    function automatic pcm_t applyGain(input pcm_t x, input gain_t g);
        logic signed [15:0] f;
        logic signed [31:0] p;
        logic signed [47:0] w;
        logic [3:0]         sh;
        unique case (g[2:0])
            3'h0: f = `FRAC_0;
            3'h1: f = `FRAC_1;
            3'h2: f = `FRAC_2;
            3'h3: f = `FRAC_3;
            3'h4: f = `FRAC_4;
            3'h5: f = `FRAC_5;
            3'h6: f = `FRAC_6;
            3'h7: f = `FRAC_7;
        endcase
        p  = x * f;
        sh = 4'((g >>> 3) + `SHIFT_BIAS);
        w  = (48'(p) <<< sh) >>> `FRAC_BITS;
        if (w > 48'(`PCM_MAX)) return `PCM_MAX;
        if (w < 48'(`PCM_MIN)) return `PCM_MIN;
        return w[15:0];
    endfunction

    // ************************************************************
    // Reset release
    // ************************************************************
    // Two-flop release of the asynchronous reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) rstSyncQ <= 2'h0;
        else rstSyncQ <= {rstSyncQ[0], 1'b1};
    end
    assign rstN = rstSyncQ[1];

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    assign idx     = wbReq.adr[9:2];
    assign reqLive = wbReq.cyc & wbReq.stb;
    assign wrHit   = reqLive & wbReq.we & ackQ;
    assign wbRsp   = {ackQ, rdatQ};

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) ackQ <= 1'b0;
        else ackQ <= reqLive & ~ackQ;
    end

    // Read mux; unmapped words read zero
    always_comb begin
        unique case (idx)
            `IDX_CTRL_A: rdMux = ctrlAQ;
            `IDX_CTRL_B: rdMux = ctrlBQ;
            `IDX_CTRL_C: rdMux = ctrlCQ;
            `IDX_CTRL_D: rdMux = ctrlDQ;
            `IDX_STATUS: rdMux = {gainQ[7:0], level};
            default:     rdMux = 16'h0000;
        endcase
    end

    // Read data captured before the ack
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) rdatQ <= '0;
        else if (reqLive && !ackQ) rdatQ <= {16'h0000, rdMux};
    end

    // Control registers, written at the ack edge
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            ctrlAQ <= `RST_CTRL_A;
            ctrlBQ <= `RST_CTRL_B;
            ctrlCQ <= `RST_CTRL_C;
            ctrlDQ <= `RST_CTRL_D;
        end else if (wrHit) begin
            unique case (idx)
                `IDX_CTRL_A: ctrlAQ <= merge(ctrlAQ, wbReq.dat, wbReq.sel);
                `IDX_CTRL_B: ctrlBQ <= merge(ctrlBQ, wbReq.dat, wbReq.sel);
                `IDX_CTRL_C: ctrlCQ <= merge(ctrlCQ, wbReq.dat, wbReq.sel);
                `IDX_CTRL_D: ctrlDQ <= merge(ctrlDQ, wbReq.dat, wbReq.sel);
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Sample paths
    // ************************************************************
    assign on          = ctrlAQ[`ON_BIT];
    assign playSel     = ctrlAQ[`PATH_BIT];
    assign actIn       = playSel ? playIn : recIn;
    assign actOutReady = playSel ? playOutReady : recOutReady;
    assign fire        = on & actIn.valid & fifoInReady;
    assign gained      = applyGain(actIn.pcm, gainQ);

    // Only the selected path is routed through the gain stage
    always_comb begin
        recOut      = recIn;
        playOut     = playIn;
        recInReady  = recOutReady;
        playInReady = playOutReady;
        if (on && !playSel) begin
            recOut     = {fifoOutValid, fifoOutPcm};
            recInReady = fifoInReady;
        end
        if (on && playSel) begin
            playOut     = {fifoOutValid, fifoOutPcm};
            playInReady = fifoInReady;
        end
    end

    // Output buffer of the processed path, flushed while off
    sample_fifo #(
        .W     (`SAMPLE_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) outBuf (
        .ref_clk  (ref_clk),
        .rst_b    (rstN),
        .clr      (~on),
        .inValid  (on & actIn.valid),
        .inReady  (fifoInReady),
        .inData   (gained),
        .outValid (fifoOutValid),
        .outReady (on & actOutReady),
        .outData  (fifoOutPcm)
    );

    // Averaged level of the selected path
    level_meter meter (
        .ref_clk (ref_clk),
        .rst_b   (rstN),
        .fire    (fire),
        .pcm     (actIn.pcm),
        .level   (level)
    );

    // ************************************************************
    // Compression curve
    // ************************************************************
    // Knee, slopes and gain limits decoded from the control words
    always_comb begin
        knee = (ctrlBQ[`KNEE_F] > `KNEE_MAX) ? `KNEE_MAX : ctrlBQ[`KNEE_F];
        kout = (ctrlCQ[`KOUT_F] > `KOUT_MAX) ? `KOUT_MAX : ctrlCQ[`KOUT_F];
        diff = $signed({4'h0, knee}) - $signed({2'h0, level});
        if (diff >= 0) begin
            // Louder than the knee: upper slope
            outAtt = $signed({5'h00, kout})
                - slope(diff, ctrlCQ[`USLOPE_F], `USLOPE_ZERO);
        end else begin
            // Quieter than the knee: lower slope
            outAtt = $signed({5'h00, kout})
                + slope(-diff, ctrlDQ[`LSLOPE_F], `LSLOPE_ZERO);
        end
        floorG = -($signed({8'h00, ctrlAQ[`FLOOR_F]}) * `FLOOR_STEP);
        unique case (ctrlAQ[`CEIL_F])
            2'h0: ceilG = `CEIL_0;
            2'h1: ceilG = `CEIL_1;
            2'h2: ceilG = `CEIL_2;
            2'h3: ceilG = `CEIL_3;
        endcase
        // Gain that brings the level onto the curve
        tgt = clampG($signed({2'h0, level}) - outAtt, floorG, ceilG);
    end

    // ************************************************************
    // Gain tracker
    // ************************************************************
    assign attCode = ctrlBQ[`ATT_F];
    assign relCode = ctrlBQ[`REL_F];
    assign attOk   = (attCode >= `ATT_MIN) && (attCode <= `ATT_MAX);
    assign relOk   = (relCode <= `REL_MAX);
    assign attLim  = ATT_SMP << (attCode - `ATT_MIN);
    assign relLim  = REL_SMP << relCode;
    assign down    = gainQ > tgt;
    assign up      = gainQ < tgt;
    assign initG   = ($signed({5'h00, ctrlDQ[`INIT_F]})
        - $signed({5'h00, `INIT_UNITY})) * `INIT_STEP;
    assign stepDue = fire && (down ? attOk && (stepCntQ + 1'b1 >= attLim)
                                   : up && relOk
                                        && (stepCntQ + 1'b1 >= relLim));

    // Enable edge detect
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) onQ <= 1'b0;
        else onQ <= on;
    end
    // Samples since the last gain step
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) stepCntQ <= '0;
        else if (!on || (!down && !up)) stepCntQ <= '0;
        else if (fire) stepCntQ <= stepDue ? '0 : stepCntQ + 1'b1;
    end

    // Working gain, one step per due sample, clamped to the limits each cycle while on
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) gainQ <= '0;
        else if (on && !onQ) gainQ <= clampG(initG, floorG, ceilG);
        else if (on) begin
            if (stepDue && down)
                gainQ <= clampG(gainQ - `GAIN_ONE, floorG, ceilG);
            else if (stepDue && up)
                gainQ <= clampG(gainQ + `GAIN_ONE, floorG, ceilG);
            else
                gainQ <= clampG(gainQ, floorG, ceilG);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstN);
    sequence enRise;
        !onQ ##0 on;
    endsequence
    sequence cfgQuiet;
        !wrHit [*2];
    endsequence
    off_bypass_a: assert property (!on |->
        recOut == recIn && playOut == playIn)
        else $error("disabled block altered a sample path");
    path_single_a: assert property (on |->
        (playSel ? recOut == recIn : playOut == playIn))
        else $error("unselected path was not passed through");
    gain_floor_a: assert property (onQ && on && $stable(ctrlAQ)
        |-> gainQ >= floorG)
        else $error("gain below floor");
    gain_ceil_a: assert property (onQ && on && $stable(ctrlAQ)
        |-> gainQ <= ceilG)
        else $error("gain above ceiling");
    start_gain_a: assert property (enRise ##0 !wrHit
        |=> gainQ == clampG($past(initG), $past(floorG), $past(ceilG)))
        else $error("startup gain not loaded on enable");
    // No register write for two cycles, so only a taken sample moves the gain
    step_sample_a: assert property ((onQ && on) ##0 cfgQuiet ##1
        (gainQ != $past(gainQ)) |-> $past(fire))
        else $error("gain moved without a sample");
    attack_dir_a: assert property (onQ && on && !wrHit
        && stepDue && down |=> gainQ < $past(gainQ))
        else $error("gain did not fall on attack step");
    bad_attack_a: assert property (onQ && on && !attOk && !up
        && $stable(ctrlAQ) |=> gainQ >= $past(gainQ))
        else $error("reserved attack code lowered the gain");
    bus_ack_a: assert property (reqLive && !ackQ |=> ackQ ##1 !ackQ)
        else $error("bus ack not a single cycle after request");
endmodule

// ===== hw/level_meter.sv
// Mean-square level meter giving attenuation in 0.75 dB units
// Assumes fire marks each sample taken on the active path
`timescale 1ns/1ps
`include "drc_cfg.svh"
module level_meter (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    // Samples
    input  wire logic         fire,
    input  level_pkg::pcm_t   pcm,
    // Level below full scale
    output logic [7:0]        level
);
    import level_pkg::*;
    logic signed [31:0] sq;
    logic [31:0]        msQ;
    logic [4:0]         top;

    assign sq = pcm * pcm;

    // Leaky average of the squared sample
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) msQ <= '0;
        else if (fire)
            msQ <= msQ + (unsigned'(sq) >> `AVG_SHIFT) - (msQ >> `AVG_SHIFT);
    end

    // Highest set bit: each bit of power is about 3 dB
    always_comb begin
        top = '0;
        for (int i = 0; i <= `MS_TOP; i++) begin
            if (msQ[i]) top = 5'(i);
        end
    end

    // Registered level
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) level <= '0;
        else level <= 8'(5'(`MS_TOP) - top) * `LVL_PER_BIT;
    end
endmodule

// ===== hw/sample_fifo.sv
// Sample FIFO with valid and ready on both sides
// Assumes one clock and a synchronous clear from the owner
`timescale 1ns/1ps
`include "drc_cfg.svh"
module sample_fifo #(
    parameter int W     = `SAMPLE_W,
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int AW    = `FIFO_AW
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    input  wire logic         clr,
    // Fill side
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    // Drain side
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    logic [W-1:0]  memQ [DEPTH];
    logic [AW-1:0] wrQ;
    logic [AW-1:0] rdQ;
    logic [AW:0]   cntQ;
    logic          wrFire;
    logic          rdFire;

    // Full and empty from the occupancy count
    assign inReady  = (cntQ != (AW+1)'(DEPTH));
    assign outValid = (cntQ != '0);
    assign wrFire   = inValid & inReady;
    assign rdFire   = outValid & outReady;
    assign outData  = memQ[rdQ];

    // Storage
    always_ff @(posedge ref_clk) begin
        if (wrFire) memQ[wrQ] <= inData;
    end

    // Pointers and count
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrQ  <= '0;
            rdQ  <= '0;
            cntQ <= '0;
        end else if (clr) begin
            wrQ  <= '0;
            rdQ  <= '0;
            cntQ <= '0;
        end else begin
            if (wrFire) wrQ <= (wrQ == AW'(DEPTH-1)) ? '0 : wrQ + 1'b1;
            if (rdFire) rdQ <= (rdQ == AW'(DEPTH-1)) ? '0 : rdQ + 1'b1;
            cntQ <= cntQ + (AW+1)'(wrFire) - (AW+1)'(rdFire);
        end
    end

    fifo_count_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (wrFire && !rdFire && !clr) |=> cntQ == $past(cntQ) + 1'b1)
        else $error("fifo count did not rise on a write");
endmodule

// ===== sim/sample_sink.sv
// Partner sink standing behind both output streams of the compressor
// Assumes stall is driven by the bench on ref_clk
`timescale 1ns/1ps
module sample_sink (
    // Clock and control
    input  wire logic ref_clk,
    input  wire logic stall,
    // Ready towards both compressor outputs
    output logic      recOutReady,
    output logic      playOutReady
);
    // Ready follows stall one cycle late, like a slow consumer
    always_ff @(posedge ref_clk) begin
        recOutReady  <= !stall;
        playOutReady <= !stall;
    end
endmodule

// ===== sim/tb_level_compressor.sv
// Bench for the level compressor: registers, bypass, FIFO and gain
// Assumes the design files and sample_sink on the compile list
`timescale 1ns/1ps
`include "drc_cfg.svh"
module tb_level_compressor;
    import level_pkg::*;
    // ****************
    // Signals
    // ****************
    logic        ref_clk  = 1'b0;
    logic        rst_b    = 1'b0;
    logic        stall    = 1'b0;
    wb_req_s     wbReq    = '0;
    wb_rsp_s     wbRsp;
    sample_s     recIn    = '0;
    sample_s     playIn   = '0;
    sample_s     recOut;
    sample_s     playOut;
    logic        recInReady;
    logic        playInReady;
    logic        recOutReady;
    logic        playOutReady;
    int          failures = 0;
    int          n_checks = 0;
    int          cycles   = 0;
    logic [15:0] rd;

    // Clock and hang guard
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            tally_and_finish();
        end
    end

    level_compressor dut_u (
        .ref_clk(ref_clk), .rst_b(rst_b), .wbReq(wbReq), .wbRsp(wbRsp),
        .recIn(recIn), .recInReady(recInReady), .recOut(recOut),
        .recOutReady(recOutReady), .playIn(playIn),
        .playInReady(playInReady), .playOut(playOut),
        .playOutReady(playOutReady)
    );
    sample_sink sink_u (
        .ref_clk(ref_clk), .stall(stall),
        .recOutReady(recOutReady), .playOutReady(playOutReady)
    );

    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic Wishbone cycle, read data lands in rd
    task automatic wb(input logic [7:0] idx, input logic we,
                      input logic [15:0] wd);
        wbReq <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'hF, {16'h0000, wd}};
        @(posedge ref_clk);
        // Wait for the answer; only the ack or the hang guard ends this wait
        while (wbRsp.ack !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = wbRsp.dat[15:0];
        wbReq <= '0;
        @(posedge ref_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        wb(`IDX_CTRL_A, 1'b0, 16'h0000);
        chk(rd, 16'h0F11);
        wb(`IDX_CTRL_C, 1'b0, 16'h0000);
        chk(rd, 16'h0484);
        wb(`IDX_CTRL_D, 1'b0, 16'h0000);
        chk(rd, 16'h0600);
        wb(`IDX_CTRL_B, 1'b1, 16'h4208);
        wb(`IDX_CTRL_B, 1'b0, 16'h0000);
        chk(rd, 16'h4208);
        wb(8'h10, 1'b0, 16'h0000);
        chk(rd, 16'h0000);
    endtask

    // Disabled: both paths are plain wires
    task automatic t_bypass();
        recIn <= '{1'b1, 16'h1234};
        playIn <= '{1'b1, 16'hA5A5};
        @(negedge ref_clk);
        chk(recOut.pcm, 16'h1234);
        chk(playOut.pcm, 16'hA5A5);
        chk({14'h0, recInReady, playInReady}, 16'h0003);
        @(posedge ref_clk);
        recIn <= '0;
        playIn <= '0;
    endtask

    // Playback processed at unity: fill until refused, then drain
    task automatic t_fifo();
        int n;
        wb(`IDX_CTRL_B, 1'b1, 16'h4200);
        wb(`IDX_CTRL_A, 1'b1, 16'hC00D);
        stall <= 1'b1;
        recIn <= '{1'b1, 16'h1111};
        n = 0;
        repeat (12) begin
            playIn <= '{1'b1, 16'h0100 + n[15:0]};
            @(negedge ref_clk);
            if (playInReady === 1'b1) n++;
            @(posedge ref_clk);
        end
        playIn <= '0;
        chk(n[15:0], 16'h0008);
        chk(recOut.pcm, 16'h1111);
        recIn <= '0;
        stall <= 1'b0;
        n = 0;
        repeat (20) begin
            @(negedge ref_clk);
            if (playOut.valid === 1'b1 && playOutReady === 1'b1) begin
                chk(playOut.pcm, 16'h0100 + n[15:0]);
                n++;
            end
        end
        chk(n[15:0], 16'h0008);
        // Back onto a rising edge before the bus is driven
        @(posedge ref_clk);
        wb(`IDX_CTRL_A, 1'b1, 16'h0000);
    endtask

    // Loud record signal with slope 0 drives gain onto the floor
    task automatic t_gain();
        int i;
        wb(`IDX_CTRL_B, 1'b1, 16'h12F0);
        wb(`IDX_CTRL_C, 1'b1, 16'hF500);
        wb(`IDX_CTRL_A, 1'b1, 16'h800D);
        for (i = 0; i < 600; i++) begin
            recIn <= '{1'b1, i[0] ? 16'h7FFF : 16'h8001};
            @(posedge ref_clk);
        end
        recIn <= '0;
        wb(`IDX_STATUS, 1'b0, 16'h0000);
        chk({8'h00, rd[15:8]}, 16'h00E8);
        wb(`IDX_CTRL_A, 1'b1, 16'h8009);
        wb(`IDX_STATUS, 1'b0, 16'h0000);
        chk({8'h00, rd[15:8]}, 16'h00F0);
    endtask

    // Startup gain far above the ceiling is held at 12 dB, and a
    // reserved attack code then never lowers it on a loud signal
    task automatic t_ceil();
        wb(`IDX_CTRL_A, 1'b1, 16'h0000);
        wb(`IDX_CTRL_D, 1'b1, 16'h1F00);
        wb(`IDX_CTRL_A, 1'b1, 16'h800C);
        wb(`IDX_STATUS, 1'b0, 16'h0000);
        chk({8'h00, rd[15:8]}, 16'h0010);
        wb(`IDX_CTRL_B, 1'b1, 16'h00F0);
        repeat (50) begin
            recIn <= '{1'b1, 16'h7FFF};
            @(posedge ref_clk);
        end
        recIn <= '0;
        wb(`IDX_STATUS, 1'b0, 16'h0000);
        chk({8'h00, rd[15:8]}, 16'h0010);
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_regs();
        t_bypass();
        t_fifo();
        t_gain();
        t_ceil();
        tally_and_finish();
    end
endmodule
